/* rtl/fla_pkg.sv */
`default_nettype none
package fla_pkg;
  localparam logic [7:0] DIM_OFFSET = 8'h01;
  localparam logic [7:0] AUX_OFFSET = 8'h02;
  localparam logic [7:0] STAT_OFFSET = 8'h03;
  localparam logic [7:0] DIM_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam int CODE_W = 4;
  localparam int STEP_W = 5;
  localparam int HI_LSB = 4;
  localparam int LO_LSB = 0;
  localparam int STAT_FRUN_BIT = 6;
  localparam int STAT_OPEN_BIT = 5;
  localparam int STAT_WARN_BIT = 4;
  localparam int STAT_HOT_BIT = 3;
  localparam int STAT_OT_BIT = 2;
  localparam int STAT_SHORT_BIT = 0;
  localparam logic [4:0] TORCH_STEP_BASE = 5'h01;
  localparam logic [4:0] FLASH_STEP_BASE = 5'h09;
  localparam logic [4:0] SENSE_SPLIT_STEP = 5'h0d;
  localparam logic [3:0] AUX_TIME_NONE = 4'h0;
  localparam logic [3:0] AUX_TIME_CONT = 4'hf;
  localparam logic [3:0] AUX_CODE_OFF = 4'h0;
  localparam int CLK_KHZ = 100000;
  localparam int AUX_STEP_MS = 100;
  localparam int AUX_STEP_CYCLES = AUX_STEP_MS * CLK_KHZ;
  typedef enum logic [2:0] {
    AUX_IDLE = 3'b001,
    AUX_TIMED = 3'b010,
    AUX_CONT = 3'b100
  } fla_aux_state_type;
endpackage
`default_nettype wire

/* rtl/fla_aux_timer.sv */
`default_nettype none
module fla_aux_timer #(
  parameter int TICK_CYCLES = fla_pkg::AUX_STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [3:0] time_code_i,
  output logic on_o
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

  fla_pkg::fla_aux_state_type state_reg;
  fla_pkg::fla_aux_state_type state_next;
  logic [CW-1:0] tick_reg;
  logic [CW-1:0] tick_next;
  logic [3:0] left_reg;
  logic [3:0] left_next;

  always_comb begin
    state_next = state_reg;
    tick_next = tick_reg;
    left_next = left_reg;
    if (stop_i) begin
      state_next = fla_pkg::AUX_IDLE;
    end else if (start_i) begin
      tick_next = '0;
      left_next = time_code_i;
      if (time_code_i == fla_pkg::AUX_TIME_NONE) begin
        state_next = fla_pkg::AUX_IDLE;
      end else if (time_code_i == fla_pkg::AUX_TIME_CONT) begin
        state_next = fla_pkg::AUX_CONT;
      end else begin
        state_next = fla_pkg::AUX_TIMED;
      end
    end else begin
      case (state_reg)
        fla_pkg::AUX_TIMED: begin
          if (tick_reg == TICK_LAST) begin
            tick_next = '0;
            left_next = left_reg - 4'h1;
            if (left_reg == 4'h1) begin
              state_next = fla_pkg::AUX_IDLE;
            end
          end else begin
            tick_next = tick_reg + CW'(1);
          end
        end
        fla_pkg::AUX_CONT: state_next = fla_pkg::AUX_CONT;
        fla_pkg::AUX_IDLE: state_next = fla_pkg::AUX_IDLE;
        default: state_next = fla_pkg::AUX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= fla_pkg::AUX_IDLE;
      tick_reg <= '0;
      left_reg <= 4'h0;
    end else if (ce_i) begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      left_reg <= left_next;
    end
  end

  assign on_o = (state_reg != fla_pkg::AUX_IDLE);
endmodule
`default_nettype wire

/* rtl/fla_regs.sv */
`default_nettype none
module fla_regs #(
  parameter int AUX_TICK_CYCLES = fla_pkg::AUX_STEP_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic READY_MODE_I,
  input wire logic FLASH_MODE_I,
  input wire logic TORCH_MODE_I,
  input wire logic LED_OPEN_CMP_I,
  input wire logic NTC_WARN_CMP_I,
  input wire logic NTC_HOT_CMP_I,
  input wire logic CHIP_OT_I,
  input wire logic STARTUP_I,
  input wire logic OUT_LEVEL_OK_I,
  input wire logic CHARGE_END_I,
  input wire logic FLASH_TIMEOUT_I,
  output logic [7:0] REG_RDATA_O,
  output logic [4:0] LED_STEP_O,
  output logic SENSE_FLASH_ONLY_O,
  output logic [3:0] FLASH_LEVEL_O,
  output logic [3:0] AUX_CURRENT_O,
  output logic AUX_ON_O,
  output logic FORCE_READY_O,
  output logic START_BLOCK_O,
  output logic ATTENTION_N_O
);

  function automatic logic [4:0] code_to_step(input logic [3:0] code,
                                               input logic [4:0] base);
    code_to_step = {1'b0, code} + base;
  endfunction

  function automatic logic step_flash_only(input logic [4:0] step);
    step_flash_only = (step >= fla_pkg::SENSE_SPLIT_STEP);
  endfunction

  function automatic logic [3:0] hi_nib(input logic [7:0] b);
    hi_nib = b[fla_pkg::HI_LSB +: fla_pkg::CODE_W];
  endfunction

  function automatic logic [3:0] lo_nib(input logic [7:0] b);
    lo_nib = b[fla_pkg::LO_LSB +: fla_pkg::CODE_W];
  endfunction

  // Register file
  logic [7:0] dim_reg;
  logic [7:0] dim_next;
  logic [7:0] aux_reg;
  logic [7:0] aux_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Status latches
  logic frun_reg;
  logic frun_next;
  logic open_reg;
  logic open_next;
  logic warn_reg;
  logic warn_next;
  logic hot_reg;
  logic hot_next;
  logic ot_reg;
  logic ot_next;
  logic short_reg;
  logic short_next;
  logic charging_reg;
  logic charging_next;

  // Drive outputs
  logic [4:0] step_reg;
  logic [4:0] step_next;
  logic sense_reg;
  logic sense_next;
  logic [3:0] flvl_reg;
  logic [3:0] flvl_next;
  logic [3:0] auxi_reg;
  logic [3:0] auxi_next;
  logic auxon_reg;
  logic auxon_next;
  logic force_reg;
  logic force_next;
  logic block_reg;
  logic block_next;
  logic attn_n_reg;
  logic attn_n_next;

  logic wr_dim;
  logic wr_aux;
  logic rd_stat;
  logic aux_start;
  logic aux_stop;
  logic aux_timer_on;
  logic [7:0] stat_view;
  logic open_set;

  assign wr_dim = REG_WR_I && (REG_ADDR_I == fla_pkg::DIM_OFFSET);
  assign wr_aux = REG_WR_I && (REG_ADDR_I == fla_pkg::AUX_OFFSET);
  assign rd_stat = REG_RD_I && (REG_ADDR_I == fla_pkg::STAT_OFFSET);

  // The current code starts the timer, and a zero code or leaving ready stops it; a zero timer field still leaves the source off
  assign aux_start = wr_aux && (hi_nib(REG_WDATA_I) != fla_pkg::AUX_CODE_OFF);
  // Leaving ready wins over a same-cycle start, so a write outside ready is inert
  assign aux_stop = !READY_MODE_I
                    || (wr_aux && (hi_nib(REG_WDATA_I) == fla_pkg::AUX_CODE_OFF));

  fla_aux_timer #(
    .TICK_CYCLES(AUX_TICK_CYCLES)
  ) u_aux_timer (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .start_i(aux_start),
    .stop_i(aux_stop),
    .time_code_i(lo_nib(REG_WDATA_I)),
    .on_o(aux_timer_on)
  );

  always_comb begin
    stat_view = 8'h00;
    stat_view[fla_pkg::STAT_FRUN_BIT] = frun_reg;
    stat_view[fla_pkg::STAT_OPEN_BIT] = open_reg;
    stat_view[fla_pkg::STAT_WARN_BIT] = warn_reg;
    stat_view[fla_pkg::STAT_HOT_BIT] = hot_reg;
    stat_view[fla_pkg::STAT_OT_BIT] = ot_reg;
    stat_view[fla_pkg::STAT_SHORT_BIT] = short_reg;
  end

  // Register writes and read data
  always_comb begin
    dim_next = dim_reg;
    aux_next = aux_reg;
    rdata_next = rdata_reg;
    if (wr_dim) begin
      dim_next = REG_WDATA_I;
    end
    if (wr_aux) begin
      aux_next = REG_WDATA_I;
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        fla_pkg::DIM_OFFSET: rdata_next = dim_reg;
        fla_pkg::AUX_OFFSET: rdata_next = aux_reg;
        fla_pkg::STAT_OFFSET: rdata_next = stat_view;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dim_reg <= fla_pkg::DIM_RESET;
      aux_reg <= fla_pkg::AUX_RESET;
      rdata_reg <= 8'h00;
    end else if (CE_I) begin
      dim_reg <= dim_next;
      aux_reg <= aux_next;
      rdata_reg <= rdata_next;
    end
  end

  // Status bits: a new event in the read cycle survives the clear
  assign open_set = LED_OPEN_CMP_I && (TORCH_MODE_I || FLASH_MODE_I);

  always_comb begin
    frun_next = FLASH_MODE_I;
    open_next = (open_reg && !rd_stat) || open_set;
    warn_next = (warn_reg && !rd_stat) || NTC_WARN_CMP_I;
    hot_next = (hot_reg && !rd_stat) || NTC_HOT_CMP_I;
    ot_next = (ot_reg && !rd_stat) || CHIP_OT_I;
    charging_next = charging_reg;
    short_next = short_reg;
    if (STARTUP_I) begin
      charging_next = 1'b1;
      short_next = 1'b1;
    end else begin
      if (OUT_LEVEL_OK_I) begin
        charging_next = 1'b0;
        short_next = 1'b0;
      end else if (CHARGE_END_I) begin
        charging_next = 1'b0;
      end
      if (rd_stat) begin
        short_next = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      frun_reg <= 1'b0;
      open_reg <= 1'b0;
      warn_reg <= 1'b0;
      hot_reg <= 1'b0;
      ot_reg <= 1'b0;
      short_reg <= 1'b0;
      charging_reg <= 1'b0;
    end else if (CE_I) begin
      frun_reg <= frun_next;
      open_reg <= open_next;
      warn_reg <= warn_next;
      hot_reg <= hot_next;
      ot_reg <= ot_next;
      short_reg <= short_next;
      charging_reg <= charging_next;
    end
  end

  // Drive and alert outputs, all registered
  always_comb begin
    flvl_next = lo_nib(dim_reg);
    step_next = 5'h00;
    if (FLASH_MODE_I) begin
      step_next = code_to_step(lo_nib(dim_reg), fla_pkg::FLASH_STEP_BASE);
    end else if (TORCH_MODE_I) begin
      step_next = code_to_step(hi_nib(dim_reg), fla_pkg::TORCH_STEP_BASE);
    end
    sense_next = step_flash_only(step_next);
    // Code passes straight to a linear DAC, about 1.33 mA per count
    auxon_next = aux_timer_on && READY_MODE_I;
    auxi_next = auxon_next ? hi_nib(aux_reg) : fla_pkg::AUX_CODE_OFF;
    // Warning alone never forces ready; the converter keeps running
    force_next = open_next || hot_next || ot_next
                 || (short_next && !charging_next);
    block_next = short_next && !charging_next;
    // Short flag alerts only after the charge window, avoiding a glitch every start
    attn_n_next = !(open_next || warn_next || hot_next || ot_next
                    || (short_next && !charging_next)
                    || FLASH_TIMEOUT_I);
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      step_reg <= 5'h00;
      sense_reg <= 1'b0;
      flvl_reg <= 4'h0;
      auxi_reg <= 4'h0;
      auxon_reg <= 1'b0;
      force_reg <= 1'b0;
      block_reg <= 1'b0;
      attn_n_reg <= 1'b1;
    end else if (CE_I) begin
      step_reg <= step_next;
      sense_reg <= sense_next;
      flvl_reg <= flvl_next;
      auxi_reg <= auxi_next;
      auxon_reg <= auxon_next;
      force_reg <= force_next;
      block_reg <= block_next;
      attn_n_reg <= attn_n_next;
    end
  end

  assign REG_RDATA_O = rdata_reg;
  assign LED_STEP_O = step_reg;
  assign SENSE_FLASH_ONLY_O = sense_reg;
  assign FLASH_LEVEL_O = flvl_reg;
  assign AUX_CURRENT_O = auxi_reg;
  assign AUX_ON_O = auxon_reg;
  assign FORCE_READY_O = force_reg;
  assign START_BLOCK_O = block_reg;
  assign ATTENTION_N_O = attn_n_reg;

endmodule
`default_nettype wire

/* sim/fla_regs_sva.sv */
`default_nettype none
module fla_regs_sva (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic READY_MODE_I,
  input wire logic FLASH_MODE_I,
  input wire logic TORCH_MODE_I,
  input wire logic LED_OPEN_CMP_I,
  input wire logic NTC_WARN_CMP_I,
  input wire logic NTC_HOT_CMP_I,
  input wire logic CHIP_OT_I,
  input wire logic [4:0] LED_STEP_O,
  input wire logic SENSE_FLASH_ONLY_O,
  input wire logic [3:0] FLASH_LEVEL_O,
  input wire logic [3:0] AUX_CURRENT_O,
  input wire logic AUX_ON_O,
  input wire logic FORCE_READY_O,
  input wire logic ATTENTION_N_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  logic aux_wr;
  assign aux_wr = CE_I && REG_WR_I && REG_ADDR_I == 8'h02 && REG_WDATA_I[7:4] != 4'h0;
  sequence s_timed;
    aux_wr && READY_MODE_I && REG_WDATA_I[3:0] != 4'h0 ##1 READY_MODE_I && CE_I && !REG_WR_I;
  endsequence
  sequence s_untimed;
    aux_wr && REG_WDATA_I[3:0] == 4'h0 ##1 CE_I && !REG_WR_I;
  endsequence
  property p_flash_step;
    FLASH_MODE_I && CE_I ##1 $stable(FLASH_LEVEL_O) |-> LED_STEP_O == FLASH_LEVEL_O + 5'h09;
  endproperty
  a_flash_step: assert property (p_flash_step) else $error("flash step wrong");
  property p_sense;
    LED_STEP_O != 5'h00 |-> SENSE_FLASH_ONLY_O == (LED_STEP_O >= 5'h0d);
  endproperty
  a_sense: assert property (p_sense) else $error("sense path wrong");
  property p_aux_zero;
    !AUX_ON_O |-> AUX_CURRENT_O == 4'h0;
  endproperty
  a_aux_zero: assert property (p_aux_zero) else $error("aux current while off");
  property p_ready;
    !READY_MODE_I && CE_I |=> !AUX_ON_O;
  endproperty
  a_ready: assert property (p_ready) else $error("aux on outside ready");
  property p_start;
    s_timed |=> AUX_ON_O && AUX_CURRENT_O == $past(REG_WDATA_I[7:4], 2);
  endproperty
  a_start: assert property (p_start) else $error("aux did not start");
  property p_untimed;
    s_untimed |=> !AUX_ON_O;
  endproperty
  a_untimed: assert property (p_untimed) else $error("aux on with timer zero");
  property p_open;
    LED_OPEN_CMP_I && (TORCH_MODE_I || FLASH_MODE_I) && CE_I |=> FORCE_READY_O && !ATTENTION_N_O;
  endproperty
  a_open: assert property (p_open) else $error("open led not handled");
  property p_hot;
    (NTC_HOT_CMP_I || CHIP_OT_I) && CE_I |=> FORCE_READY_O && !ATTENTION_N_O;
  endproperty
  a_hot: assert property (p_hot) else $error("over-temperature not handled");
  property p_warn;
    NTC_WARN_CMP_I && CE_I |=> !ATTENTION_N_O;
  endproperty
  a_warn: assert property (p_warn) else $error("warning without attention");
endmodule
bind fla_regs fla_regs_sva fla_regs_sva_i (.*);
`default_nettype wire

/* sim/fla_host.sv */
`default_nettype none
module fla_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Aux on and off goes through the current code; a zero timer field leaves it off
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic CE_I = 1'b1;
  logic READY_MODE_I = 1'b0;
  logic FLASH_MODE_I = 1'b0;
  logic TORCH_MODE_I = 1'b0;
  logic STARTUP_I = 1'b0;
  logic OUT_LEVEL_OK_I = 1'b0;
  logic CHARGE_END_I = 1'b0;
  logic FLASH_TIMEOUT_I = 1'b0;
  logic [3:0] flt = 4'h0;
  logic LED_OPEN_CMP_I, NTC_WARN_CMP_I, NTC_HOT_CMP_I, CHIP_OT_I;
  logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, d, r;
  logic REG_WR_I, REG_RD_I, SENSE_FLASH_ONLY_O, AUX_ON_O, FORCE_READY_O;
  logic START_BLOCK_O, ATTENTION_N_O;
  logic [4:0] LED_STEP_O, s;
  logic [3:0] FLASH_LEVEL_O, AUX_CURRENT_O, cu;
  logic [3:0] tcs [5] = '{4'h0, 4'h1, 4'h3, 4'he, 4'hf};
  logic [7:0] ex [5] = '{8'h00, 8'h04, 8'h0c, 8'h38, 8'h50};
  int n_mismatch = 0;
  int total_checks = 0;
  assign {LED_OPEN_CMP_I, NTC_WARN_CMP_I, NTC_HOT_CMP_I, CHIP_OT_I} = flt;
  always #5 MCLK_I = ~MCLK_I;
  // Short tick keeps the aux timer windows within a few dozen cycles
  fla_regs #(.AUX_TICK_CYCLES(4)) fla_regs_i (.*);
  fla_host fla_host_i (.clk_i(MCLK_I), .rdata_i(REG_RDATA_O), .addr_o(REG_ADDR_I),
    .wr_o(REG_WR_I), .rd_o(REG_RD_I), .wdata_o(REG_WDATA_I));
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK_I);
    #1;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic aux_cnt(input int n, input logic [3:0] c4, input logic [7:0] e);
    int c;
    c = 0;
    repeat (n) begin
      tick(1);
      if (AUX_ON_O === 1'b1) c++;
      chk({4'h0, AUX_CURRENT_O}, (AUX_ON_O === 1'b1) ? {4'h0, c4} : 8'h00);
    end
    chk(8'(c), e);
  endtask
  function automatic logic [4:0] step_of(input logic [7:0] v, input logic fl);
    return fl ? 5'(v[3:0]) + 5'h09 : 5'(v[7:4]) + 5'h01;
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h0b40));
    tick(16);
    RST_B_I = 1'b1;
    fla_host_i.rd(8'h10, r);
    chk(r, 8'h00);
    for (int a = 1; a < 4; a++) begin
      fla_host_i.rd(8'(a), r);
      chk(r, 8'h00);
    end
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      fla_host_i.wr(8'h01, d);
      fla_host_i.rd(8'h01, r);
      chk(r, d);
      for (int m = 0; m < 2; m++) begin
        FLASH_MODE_I = m[0];
        TORCH_MODE_I = ~m[0];
        tick(3);
        s = step_of(d, m[0]);
        chk({2'b00, SENSE_FLASH_ONLY_O, LED_STEP_O}, {2'b00, s >= 5'h0d, s});
        chk({4'h0, FLASH_LEVEL_O}, {4'h0, d[3:0]});
      end
      fla_host_i.rd(8'h03, r);
      chk(r, 8'h40);
      FLASH_MODE_I = 1'b0;
      tick(2);
    end
    fla_host_i.rd(8'h03, r);
    chk(r, 8'h00);
    $display("dim test done");
    READY_MODE_I = 1'b1;
    for (int i = 0; i < 5; i++) begin
      cu = 4'h1 + 4'($urandom % 15);
      fla_host_i.wr(8'h02, {cu, tcs[i]});
      aux_cnt(80, cu, ex[i]);
      fla_host_i.rd(8'h02, r);
      chk(r, {cu, tcs[i]});
      fla_host_i.wr(8'h02, {4'h0, tcs[i]});
      aux_cnt(4, cu, 8'h00);
    end
    fla_host_i.wr(8'h02, 8'h52);
    tick(3);
    READY_MODE_I = 1'b0;
    aux_cnt(3, 4'h5, 8'h00);
    READY_MODE_I = 1'b1;
    aux_cnt(4, 4'h5, 8'h00);
    fla_host_i.wr(8'h02, 8'h52);
    aux_cnt(20, 4'h5, 8'h08);
    $display("aux test done");
    // Clock enable low must freeze the on-time count mid-way
    fla_host_i.wr(8'h02, 8'h51);
    tick(1);
    CE_I = 1'b0;
    tick(10);
    chk({3'h0, AUX_ON_O, AUX_CURRENT_O}, 8'h15);
    CE_I = 1'b1;
    aux_cnt(10, 4'h5, 8'h03);
    $display("enable test done");
    TORCH_MODE_I = 1'b1;
    for (int k = 0; k < 4; k++) begin
      flt = 4'h1 << k;
      tick(1);
      flt = 4'h0;
      tick(1);
      chk({6'h00, FORCE_READY_O, ATTENTION_N_O}, {6'h00, k != 2, 1'b0});
      fla_host_i.rd(8'h03, r);
      chk(r, {2'b00, 4'h1 << k, 2'b00});
      fla_host_i.rd(8'h03, r);
      chk(r, 8'h00);
    end
    TORCH_MODE_I = 1'b0;
    STARTUP_I = 1'b1;
    tick(1);
    STARTUP_I = 1'b0;
    CHARGE_END_I = 1'b1;
    tick(1);
    CHARGE_END_I = 1'b0;
    tick(1);
    chk({6'h00, START_BLOCK_O, ATTENTION_N_O}, 8'h02);
    fla_host_i.rd(8'h03, r);
    chk(r, 8'h01);
    tick(1);
    chk({6'h00, START_BLOCK_O, ATTENTION_N_O}, 8'h01);
    // Output reaching its level inside the charge window clears the flag silently
    STARTUP_I = 1'b1;
    tick(1);
    STARTUP_I = 1'b0;
    OUT_LEVEL_OK_I = 1'b1;
    tick(1);
    OUT_LEVEL_OK_I = 1'b0;
    tick(1);
    chk({6'h00, START_BLOCK_O, ATTENTION_N_O}, 8'h01);
    fla_host_i.rd(8'h03, r);
    chk(r, 8'h00);
    $display("status test done");
    FLASH_TIMEOUT_I = 1'b1;
    tick(2);
    chk({7'h00, ATTENTION_N_O}, 8'h00);
    FLASH_TIMEOUT_I = 1'b0;
    tick(2);
    chk({7'h00, ATTENTION_N_O}, 8'h01);
    $display("alert test done");
    give_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
